/* File: hw/fsfr_pkg.sv */
// Holds the constants of the fault status and flag register bank.
// Assumes an upstream serial host decoder that presents byte-wide register accesses.
package fsfr_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] SUPPLY_MASK_ADDR = 8'h08; // Supply fault masks
   localparam logic [7:0] BUF_MASK_ADDR    = 8'h09; // Buffer fault masks
   localparam logic [7:0] SUPPLY_FLAG_ADDR = 8'h0A; // Supply fault flags
   localparam logic [7:0] BUF_FLAG_ADDR    = 8'h0B; // Buffer, thermal, reset flags

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int SUPPLY_W         = 7; // Supply flags occupy bits 6..0
   localparam int BUF_W            = 2; // Buffer under and over
   localparam int BUF_UNDER_BIT    = 4; // Buffer undervoltage position
   localparam int BUF_OVER_BIT     = 3; // Buffer overvoltage position
   localparam int THERMAL_BIT      = 1; // Thermal shutdown position
   localparam int POWER_ON_BIT     = 0; // Power-on position

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [6:0] SUPPLY_RST   = 7'h00; // Flags clear at reset
   localparam logic [1:0] BUF_RST      = 2'h0;  // Buffer flags clear
   localparam logic [6:0] MASK1_RST    = 7'h00; // Supply masks open
   localparam logic [1:0] MASK2_RST    = 2'h0;  // Buffer masks open
   localparam logic       POWER_ON_RST = 1'h1;  // Power-on flag set
   localparam logic [7:0] UNMAPPED_RD  = 8'h00; // Unmapped address reads zero
endpackage

/* File: hw/fsfr_flag_cell.sv */
// Holds a vector of fault flags, live or latched with clear.
// Assumes fault inputs already synchronised to ref_clk_i.
`timescale 1ns/10ps
module fsfr_flag_cell
   import fsfr_pkg::*;
#(
   parameter int             WIDTH = 1,
   parameter logic [WIDTH-1:0] RST = '0
)(
   input  wire logic             ref_clk_i, // Core clock
   input  wire logic             srst_i,    // Synchronous reset
   input  wire logic             live_i,    // One: flags follow status
   input  wire logic [WIDTH-1:0] fault_i,   // Present fault conditions
   input  wire logic [WIDTH-1:0] clr_i,     // Per-bit clear request
   output logic      [WIDTH-1:0] flag_o     // Flag state
);
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] next_flag; // Next flag value
   logic [WIDTH-1:0] kept;      // Latched flags surviving clear

   assign kept = flag_o & ~clr_i;
   assign next_flag = live_i ? fault_i : (kept | fault_i);

   // Flag register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         flag_o <= RST;
      end else begin
         flag_o <= next_flag;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   live_follow_a: assert property (
      live_i |=> flag_o == $past(fault_i))
      else $error("live flag does not follow status");
   latch_keep_a: assert property (
      (!live_i && clr_i == '0) |=> ($past(flag_o) & ~flag_o) == '0)
      else $error("latched flag dropped without clear");
   reassert_a: assert property (
      !live_i |=> (flag_o & $past(fault_i)) == $past(fault_i))
      else $error("present fault not reasserted");
   live_clear_c: cover property ((live_i && fault_i != '0) ##1 (live_i && fault_i == '0));
endmodule

/* File: hw/fsfr_fault_regs.sv */
// Holds the fault register bank: masks, flags, readback and fault output.
// Assumes byte accesses from a serial host decoder on ref_clk_i and
// asynchronous comparator levels on the fault inputs.
`timescale 1ns/10ps

// Operation
// - Buffer under mask blocks output
// - Buffer over mask blocks output
// - Supply flag register layout, reset zero
// - Latch disabled: supply and buffer bits show live status; thermal stays latched
// - Latched: set, clear on read, reassert
// - Write zero clears; reads return value
// - Buffer register layout bits 4,3,1,0
// - Buffer flags share live/latched selection
// - Thermal flag latches, clears on read
// - Power-on flag reads one once
// - Supply masks block their faults
module fsfr_fault_regs
   import fsfr_pkg::*;
(
   input  wire logic       ref_clk_i,         // Core clock, 250 MHz
   input  wire logic       srst_i,            // Synchronous reset, active high
   input  wire logic       fault_latch_dis_i, // One: live status mode
   input  wire logic       neg_gate_under_i,  // Comparator levels
   input  wire logic       neg_gate_over_i,
   input  wire logic       pos_gate_under_i,
   input  wire logic       pos_gate_over_i,
   input  wire logic       analog_overload_i,
   input  wire logic       boost_out_under_i,
   input  wire logic       boost_out_over_i,
   input  wire logic       buf_under_i,
   input  wire logic       buf_over_i,
   input  wire logic       thermal_off_i,
   input  wire logic       reg_wr_i,          // Write strobe, one cycle
   input  wire logic       reg_rd_i,          // Read strobe, one cycle
   input  wire logic [7:0] reg_addr_i,        // Register offset
   input  wire logic [7:0] reg_wdata_i,       // Write data
   output logic      [7:0] reg_rdata_o,       // Read data
   output logic            reg_rvalid_o,      // Read data valid pulse
   output logic            fault_out_n_o      // Fault output, active low
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   localparam int NF = SUPPLY_W + BUF_W + 1; // Synchronised fault count

   logic [NF-1:0] raw_fault;  // Unsynchronised levels
   logic [NF-1:0] sync_meta;  // First stage, read only by second
   logic [NF-1:0] sync_fault; // Second stage

   assign raw_fault = {thermal_off_i, buf_under_i, buf_over_i,
                       neg_gate_under_i, neg_gate_over_i, pos_gate_under_i,
                       pos_gate_over_i, analog_overload_i, boost_out_under_i,
                       boost_out_over_i};

   // Two-stage synchroniser
   always_ff @(posedge ref_clk_i) begin
      sync_meta  <= raw_fault;
      sync_fault <= sync_meta;
   end

   // ---------------------------------------------------------------
   // Address decode and clear requests
   // ---------------------------------------------------------------
   logic                wr_m1, wr_m2, wr_f1, wr_f2; // Write hits
   logic                rd_f1, rd_f2;               // Read hits
   logic [SUPPLY_W-1:0] clr_supply;                 // Supply clears
   logic [BUF_W-1:0]    clr_buf;                    // Buffer clears
   logic                clr_thermal;                // Thermal clear
   logic [BUF_W-1:0]    wr_buf_bits;                // Buffer fields of write data

   assign wr_m1 = reg_wr_i && (reg_addr_i == SUPPLY_MASK_ADDR);
   assign wr_m2 = reg_wr_i && (reg_addr_i == BUF_MASK_ADDR);
   assign wr_f1 = reg_wr_i && (reg_addr_i == SUPPLY_FLAG_ADDR);
   assign wr_f2 = reg_wr_i && (reg_addr_i == BUF_FLAG_ADDR);
   assign rd_f1 = reg_rd_i && (reg_addr_i == SUPPLY_FLAG_ADDR);
   assign rd_f2 = reg_rd_i && (reg_addr_i == BUF_FLAG_ADDR);
   assign wr_buf_bits = {reg_wdata_i[BUF_UNDER_BIT], reg_wdata_i[BUF_OVER_BIT]};

   assign clr_supply  = {SUPPLY_W{rd_f1}} | ({SUPPLY_W{wr_f1}} & ~reg_wdata_i[SUPPLY_W-1:0]);
   assign clr_buf     = {BUF_W{rd_f2}} | ({BUF_W{wr_f2}} & ~wr_buf_bits);
   assign clr_thermal = rd_f2 | (wr_f2 && !reg_wdata_i[THERMAL_BIT]);

   // ---------------------------------------------------------------
   // Flag storage
   // ---------------------------------------------------------------
   logic [SUPPLY_W-1:0] supply_flags;     // Bits 6..0 of the supply flag register
   logic [BUF_W-1:0]    buf_flags;        // {buf_under_flag, buf_over_flag}
   logic                thermal_off_flag; // Thermal shutdown flag
   logic                power_on_flag;    // Power-on indication

   fsfr_flag_cell #(.WIDTH(SUPPLY_W), .RST(SUPPLY_RST)) u_supply (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .live_i    (fault_latch_dis_i),
      .fault_i   (sync_fault[SUPPLY_W-1:0]),
      .clr_i     (clr_supply),
      .flag_o    (supply_flags)
   );

   fsfr_flag_cell #(.WIDTH(BUF_W), .RST(BUF_RST)) u_buf (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .live_i    (fault_latch_dis_i),
      .fault_i   (sync_fault[SUPPLY_W+BUF_W-1:SUPPLY_W]),
      .clr_i     (clr_buf),
      .flag_o    (buf_flags)
   );

   fsfr_flag_cell #(.WIDTH(1), .RST(1'h0)) u_thermal (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .live_i    (1'b0),
      .fault_i   (sync_fault[NF-1]),
      .clr_i     (clr_thermal),
      .flag_o    (thermal_off_flag)
   );

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         power_on_flag <= POWER_ON_RST;
      end else if (rd_f2) begin
         power_on_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Mask registers
   // ---------------------------------------------------------------
   logic [SUPPLY_W-1:0] supply_masks; // One blocks the fault
   logic [BUF_W-1:0]    buf_masks;    // {buf_under_mask, buf_over_mask}

   // Mask writes
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         supply_masks <= MASK1_RST;
         buf_masks    <= MASK2_RST;
      end else begin
         if (wr_m1) begin
            supply_masks <= reg_wdata_i[SUPPLY_W-1:0];
         end
         if (wr_m2) begin
            buf_masks <= wr_buf_bits;
         end
      end
   end

   // ---------------------------------------------------------------
   // Readback
   // ---------------------------------------------------------------
   logic [7:0] rd_word; // Selected register image
   logic [7:0] buf_img; // Buffer flag register image
   logic [7:0] m2_img;  // Buffer mask register image

   assign buf_img = (8'(buf_flags[1]) << BUF_UNDER_BIT) | (8'(buf_flags[0]) << BUF_OVER_BIT)
                  | (8'(thermal_off_flag) << THERMAL_BIT) | (8'(power_on_flag) << POWER_ON_BIT);
   assign m2_img  = (8'(buf_masks[1]) << BUF_UNDER_BIT) | (8'(buf_masks[0]) << BUF_OVER_BIT);
   assign rd_word = (reg_addr_i == SUPPLY_FLAG_ADDR) ? 8'(supply_flags) :
                    (reg_addr_i == BUF_FLAG_ADDR)    ? buf_img :
                    (reg_addr_i == SUPPLY_MASK_ADDR) ? 8'(supply_masks) :
                    (reg_addr_i == BUF_MASK_ADDR)    ? m2_img : UNMAPPED_RD;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         reg_rdata_o  <= UNMAPPED_RD;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rd_word;
         end
      end
   end

   // ---------------------------------------------------------------
   // Fault output
   // ---------------------------------------------------------------
   logic pending; // Any unmasked fault flag

   assign pending = (|(supply_flags & ~supply_masks)) | (|(buf_flags & ~buf_masks))
                  | thermal_off_flag;

   // Output register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         fault_out_n_o <= 1'b1;
      end else begin
         fault_out_n_o <= !pending;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   buf_under_mask_a: assert property (
      (buf_flags == 2'h2 && buf_masks[1] && !thermal_off_flag
         && (supply_flags & ~supply_masks) == '0) |=> fault_out_n_o)
      else $error("masked buffer undervoltage pulled output");
   buf_over_mask_a: assert property (
      (buf_flags == 2'h1 && buf_masks[0] && !thermal_off_flag
         && (supply_flags & ~supply_masks) == '0) |=> fault_out_n_o)
      else $error("masked buffer overvoltage pulled output");
   supply_mask_a: assert property (
      (supply_flags != '0 && (supply_flags & ~supply_masks) == '0
         && (buf_flags & ~buf_masks) == '0 && !thermal_off_flag) |=> fault_out_n_o)
      else $error("masked supply fault pulled output");
   fault_drive_a: assert property (
      ((supply_flags & ~supply_masks) != '0) |=> !fault_out_n_o)
      else $error("unmasked supply fault left output high");
   buf_drive_a: assert property (
      ((buf_flags & ~buf_masks) != '0) |=> !fault_out_n_o)
      else $error("unmasked buffer fault left output high");
   read_back_a: assert property (
      rd_f1 |=> (reg_rvalid_o && reg_rdata_o == 8'($past(supply_flags))))
      else $error("supply flag readback wrong");
   power_on_a: assert property (
      rd_f2 |=> !power_on_flag)
      else $error("power-on flag still set after read");
   power_reset_a: assert property (
      $past(srst_i) |-> power_on_flag)
      else $error("power-on flag not set after reset");
   thermal_set_a: assert property (
      sync_fault[NF-1] |=> thermal_off_flag)
      else $error("thermal flag not set");
   write_one_a: assert property (
      (wr_f1 && reg_wdata_i == 8'hFF && !fault_latch_dis_i)
         |=> ($past(supply_flags) & ~supply_flags) == '0)
      else $error("write of one cleared a flag");

   fault_read_c: cover property (supply_flags != '0 ##1 rd_f1 ##1 reg_rvalid_o);
   power_read_c: cover property (power_on_flag && rd_f2);
   masked_buf_c: cover property (buf_flags != '0 && buf_masks == 2'h3 && fault_out_n_o);
   reassert_c:   cover property (rd_f1 && !fault_latch_dis_i
                                 && (sync_fault[SUPPLY_W-1:0] & supply_flags) != '0);
endmodule

/* File: tb/fsfr_host_model.sv */
// Host model: single-byte reads and writes on the fault register port.
// Assumes read data comes with a valid pulse one cycle after the read strobe.
`timescale 1ns/10ps
module fsfr_host_model (
   input  wire logic       ref_clk_i,    // Core clock
   input  wire logic [7:0] reg_rdata_i,  // Read data
   input  wire logic       reg_rvalid_i, // Read data valid
   output logic            reg_wr_o,     // Write strobe
   output logic            reg_rd_o,     // Read strobe
   output logic      [7:0] reg_addr_o,   // Register offset
   output logic      [7:0] reg_wdata_o   // Write data
);
   // Quiet bus at time zero
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
   end

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk_i);
      reg_wr_o    <= 1'b1;
      reg_addr_o  <= addr;
      reg_wdata_o <= data;
      @(posedge ref_clk_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~addr; // Released lines stop showing old values
      reg_wdata_o <= ~data;
   endtask

   // One strobe cycle; the answer must be there at the very next edge
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(posedge ref_clk_i);
      reg_rd_o   <= 1'b1;
      reg_addr_o <= addr;
      @(posedge ref_clk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~addr;
      @(posedge ref_clk_i);
      ok   = (reg_rvalid_i === 1'b1);
      data = reg_rdata_i;
   endtask
endmodule

/* File: tb/test_fsfr_fault_regs.sv */
// Testbench of the fault register bank: registers through the host model,
// fault levels driven straight onto the comparator inputs.
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module test_fsfr_fault_regs
   import fsfr_pkg::*;
;
   logic       ref_clk;     // Core clock
   logic       srst;        // Synchronous reset
   logic       latch_dis;   // One: live status
   logic [9:0] flt;         // 6..0 supply, 7 buf over, 8 buf under, 9 thermal
   logic       reg_wr;      // Host write strobe
   logic       reg_rd;      // Host read strobe
   logic [7:0] reg_addr;    // Host offset
   logic [7:0] reg_wdata;   // Host write data
   logic [7:0] reg_rdata;   // Read data
   logic       reg_rvalid;  // Read valid
   logic       fault_out_n; // Fault output
   logic [7:0] rdata;       // Last read value
   logic       ok;          // Read answered in time
   logic [7:0] ea;          // Expected register
   logic [7:0] ev;          // Expected value
   int         fail_count;
   int         n_checks;

   fsfr_fault_regs u_dut (
      .ref_clk_i(ref_clk), .srst_i(srst), .fault_latch_dis_i(latch_dis),
      .neg_gate_under_i(flt[6]), .neg_gate_over_i(flt[5]), .pos_gate_under_i(flt[4]),
      .pos_gate_over_i(flt[3]), .analog_overload_i(flt[2]), .boost_out_under_i(flt[1]),
      .boost_out_over_i(flt[0]), .buf_under_i(flt[8]), .buf_over_i(flt[7]),
      .thermal_off_i(flt[9]), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
      .fault_out_n_o(fault_out_n)
   );
   fsfr_host_model u_host (
      .ref_clk_i(ref_clk), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
      .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata)
   );

   // Verdict and end of run
   task automatic print_verdict;
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Apply fault levels, then let sync, flag and output settle
   task automatic set_flt(input logic [9:0] v);
      @(posedge ref_clk);
      flt <= v;
      repeat (6) @(posedge ref_clk);
   endtask

   // Read and compare; a missing answer counts as a failure
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      u_host.read_reg(addr, rdata, ok);
      `CHK(ok, 1'h1) // Answer one cycle on
      `CHK(rdata, exp) // Read value
   endtask

   // Clock, 4 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Main sequence
   initial begin
      srst       = 1'b1;
      latch_dis  = 1'b0;
      flt        = 10'h000;
      fail_count = 0;
      n_checks   = 0;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      rd(BUF_FLAG_ADDR, 8'h01); // Power-on seen once
      rd(BUF_FLAG_ADDR, 8'h00); // Then zero
      rd(SUPPLY_FLAG_ADDR, 8'h00); // Reset zero
      rd(8'h0C, UNMAPPED_RD); // Unmapped offset
      u_host.write_reg(BUF_FLAG_ADDR, 8'hFF); // Ones set nothing
      rd(BUF_FLAG_ADDR, 8'h00); // Ones and read-only ignored
      // Each fault alone, latched mode
      for (int j = 0; j < 10; j++) begin
         ea = (j < 7) ? SUPPLY_FLAG_ADDR : BUF_FLAG_ADDR;
         ev = (j < 7) ? (8'h01 << j) : ((j == 7) ? 8'h08 : ((j == 8) ? 8'h10 : 8'h02));
         set_flt(10'h001 << j); // Raise one fault
         `CHK(fault_out_n, 1'b0) // Unmasked fault drives low
         set_flt(10'h000); // Fault gone, flag held
         rd(ea, ev); // Latched bit position
         rd(ea, 8'h00); // Cleared by read
         `CHK(fault_out_n, 1'b1) // Released
      end
      // Persisting fault sets again after each read
      for (int k = 0; k < 2; k++) begin
         ea = k ? BUF_FLAG_ADDR : SUPPLY_FLAG_ADDR;
         ev = k ? 8'h02 : 8'h04;
         set_flt(k ? 10'h200 : 10'h004); // Persisting fault
         rd(ea, ev); // Set
         rd(ea, ev); // Sets again while present
         set_flt(10'h000); // Fault gone
         rd(ea, ev); // Last latch
         rd(ea, 8'h00); // Clear
      end
      // Write zero clears, write one keeps
      set_flt(10'h024); // Two supply faults
      set_flt(10'h000); // Faults gone, flags held
      u_host.write_reg(SUPPLY_FLAG_ADDR, 8'hFF); // Ones keep flags
      u_host.write_reg(SUPPLY_FLAG_ADDR, 8'hDF); // Zero clears bit 5
      rd(SUPPLY_FLAG_ADDR, 8'h04); // Only bit 5 cleared
      set_flt(10'h024); // Latch both again
      set_flt(10'h000); // Faults gone, flags held
      u_host.write_reg(SUPPLY_FLAG_ADDR, 8'h00); // Zero clears all
      rd(SUPPLY_FLAG_ADDR, 8'h00); // Write zero clears
      // Masks keep faults off the output
      u_host.write_reg(SUPPLY_MASK_ADDR, 8'h7F); // Mask all supply
      u_host.write_reg(BUF_MASK_ADDR, 8'h18); // Mask both buffer
      rd(SUPPLY_MASK_ADDR, 8'h7F); // Mask readback
      rd(BUF_MASK_ADDR, 8'h18); // Mask readback
      set_flt(10'h1FF); // All but thermal
      `CHK(fault_out_n, 1'b1) // All masked
      u_host.write_reg(BUF_MASK_ADDR, 8'h08); // Unmask
      repeat (3) @(posedge ref_clk);
      `CHK(fault_out_n, 1'b0) // Under unmasked
      u_host.write_reg(BUF_MASK_ADDR, 8'h10); // Unmask over
      repeat (3) @(posedge ref_clk);
      `CHK(fault_out_n, 1'b0) // Over unmasked
      set_flt(10'h000); // Faults gone
      rd(SUPPLY_FLAG_ADDR, 8'h7F); // Masked faults still flagged
      rd(BUF_FLAG_ADDR, 8'h18); // Both buffer flags
      u_host.write_reg(SUPPLY_MASK_ADDR, 8'h00); // Open supply masks
      u_host.write_reg(BUF_MASK_ADDR, 8'h00); // Open buffer masks
      repeat (3) @(posedge ref_clk);
      `CHK(fault_out_n, 1'b1) // Nothing left
      // One buffer fault under its own mask
      u_host.write_reg(BUF_MASK_ADDR, 8'h10); // Mask under only
      set_flt(10'h100); // Under alone
      `CHK(fault_out_n, 1'h1) // Masked under stays off
      set_flt(10'h000); // Under gone
      rd(BUF_FLAG_ADDR, 8'h10); // Under latched
      u_host.write_reg(BUF_MASK_ADDR, 8'h08); // Mask over only
      set_flt(10'h080); // Over alone
      `CHK(fault_out_n, 1'h1) // Masked over stays off
      set_flt(10'h000); // Over gone
      rd(BUF_FLAG_ADDR, 8'h08); // Over latched
      u_host.write_reg(BUF_MASK_ADDR, 8'h00); // Open buffer masks
      // Live status mode
      latch_dis <= 1'b1;
      set_flt(10'h188); // Live faults
      `CHK(fault_out_n, 1'h0) // Live fault drives low
      rd(SUPPLY_FLAG_ADDR, 8'h08); // Present fault
      rd(SUPPLY_FLAG_ADDR, 8'h08); // Read does not clear
      rd(BUF_FLAG_ADDR, 8'h18); // Buffer live
      set_flt(10'h000); // Faults gone
      `CHK(fault_out_n, 1'h1) // Live release
      rd(SUPPLY_FLAG_ADDR, 8'h00); // Gone, reads zero
      rd(BUF_FLAG_ADDR, 8'h00); // Gone
      latch_dis <= 1'b0;
      u_host.write_reg(BUF_MASK_ADDR, 8'h18); // Masks set before reset
      // Second reset in mid-run
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      u_host.write_reg(BUF_FLAG_ADDR, 8'h00); // Read-only power-on kept
      rd(BUF_FLAG_ADDR, 8'h01); // Power-on again
      rd(BUF_MASK_ADDR, 8'h00); // Masks back to zero
      print_verdict();
   end
endmodule
